// >>> pkg/mdio_port_pkg.sv
// shared constants and types for the serial management port
package mdio_port_pkg;

	// ==========================================================
	// field widths and counts
	localparam int unsigned REG_COUNT    = 32;
	localparam int unsigned REG_W        = 16;
	localparam int unsigned ADDR_W       = 5;
	localparam int unsigned PREAMBLE_LEN = 32;
	localparam int unsigned OP_LEN       = 2;
	localparam int unsigned DATA_LEN     = 16;

	// ==========================================================
	// frame codes
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;

	// ==========================================================
	// register offsets, fields and reset values
	localparam logic [4:0]  ADDR_CONTROL      = 5'h00;
	localparam logic [4:0]  ADDR_BASIC_STATUS = 5'h01;
	localparam int unsigned SOFT_RESET_BIT    = 15;
	localparam int unsigned PRE_SUPPRESS_BIT  = 6;
	localparam logic [15:0] REG_RESET         = 16'h0000;

	// ==========================================================
	// frame engine states
	typedef enum logic [3:0] {
		ST_PREAMBLE = 4'h0,
		ST_IDLE     = 4'h1,
		ST_START2   = 4'h2,
		ST_OP       = 4'h3,
		ST_PHY      = 4'h4,
		ST_REG      = 4'h5,
		ST_TA1      = 4'h6,
		ST_TA2      = 4'h7,
		ST_DATA     = 4'h8
	} frame_state_e;

endpackage : mdio_port_pkg

// >>> pkg/mdio_link_if.sv
// sampled management link events passed from sampler to frame engine
`timescale 1ns/1ps
interface mdio_link_if;
	logic mdc_rise;
	logic mdc_fall;
	logic mdio_bit;

	modport sampler (output mdc_rise, output mdc_fall, output mdio_bit);
	modport engine  (input mdc_rise, input mdc_fall, input mdio_bit);
endinterface : mdio_link_if

// >>> core/mdio_link_sampler.sv
// synchronises management clock and data pins and finds clock edges
`timescale 1ns/1ps
module mdio_link_sampler (
	input  wire logic   clk_i,
	input  wire logic   reset_i,
	input  wire logic   mdc_i,
	input  wire logic   mdio_i,
	mdio_link_if.sampler link
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [2:0] mdc_sh;
		logic [1:0] mdio_sh;
	} sampler_s;

	sampler_s q;
	sampler_s d;

	always_comb begin
		d         = q;
		d.mdc_sh  = {q.mdc_sh[1:0], mdc_i};
		d.mdio_sh = {q.mdio_sh[0], mdio_i};
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// only second and third stages are looked at; data shares the clock's latency
	assign link.mdc_rise = q.mdc_sh[1] & ~q.mdc_sh[2];
	assign link.mdc_fall = ~q.mdc_sh[1] & q.mdc_sh[2];
	assign link.mdio_bit = q.mdio_sh[1];

endmodule : mdio_link_sampler

// >>> core/mdio_management_port.sv
// serial management port frame engine with its register file
`timescale 1ns/1ps
// Overview of operation
// - thirty-two 16-bit registers reachable only through management clock and data.
// - up to 32 devices share data; five-bit device address picks the responder.
// - after reset ignore frames and never drive until full preamble seen.
// - stay synced; lose sync on reset, bad start, bad opcode or bad turnaround.
// - each frame starts with bits zero then one after idle high bits.
// - fields: idle, start, opcode, device addr, reg addr, turnaround, data, idle.
// - in read turnaround first bit nobody drives the data line.
// - matched read: drive zero in second turnaround bit, then sixteen data bits.
// - basic status register at address 01h reports bit 6 set.
// - after the first preamble accept frames carrying no preamble.
module mdio_management_port (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        mdc_i,
	input  wire logic        mdio_i,
	output logic             mdio_o,
	output logic             mdio_oe_o,
	input  wire logic [4:0]  phy_addr_i,
	input  wire logic [15:0] status_i,
	output logic             in_sync_o,
	output logic             wr_pulse_o,
	output logic [4:0]       wr_addr_o,
	output logic [15:0]      wr_data_o
);

	// ==========================================================
	// link sampling
	mdio_link_if link ();

	mdio_link_sampler u_sampler (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.mdc_i   (mdc_i),
		.mdio_i  (mdio_i),
		.link    (link)
	);

	// ==========================================================
	// state
	typedef struct packed {
		mdio_port_pkg::frame_state_e st;
		logic [5:0]                  cnt;
		logic [1:0]                  op;
		logic [4:0]                  phy;
		logic [4:0]                  reg_addr;
		logic [15:0]                 shift;
		logic                        match;
		logic                        mdio_out;
		logic                        mdio_oe;
		logic                        in_sync;
		logic                        wr_pulse;
		logic [4:0]                  wr_addr;
		logic [15:0]                 wr_data;
		logic [4:0]                  addr_s1;
		logic [4:0]                  addr_s2;
		logic [31:0][15:0]           regs;
	} port_s;

	port_s q;
	port_s d;

	// ==========================================================
	// helpers
	function automatic logic [15:0] read_word(
		input logic [31:0][15:0] regs,
		input logic [4:0]        addr,
		input logic [15:0]       status
	);
		logic [15:0] w;
		w = regs[addr];
		if (addr == mdio_port_pkg::ADDR_BASIC_STATUS) begin
			w                                 = status;
			w[mdio_port_pkg::PRE_SUPPRESS_BIT] = 1'b1;
		end
		return w;
	endfunction : read_word

	function automatic logic last_bit(input logic [5:0] cnt, input int unsigned len);
		return cnt == 6'(len - 1);
	endfunction : last_bit

	// ==========================================================
	// frame engine
	always_comb begin
		logic b;
		logic lose;
		b          = link.mdio_bit;
		lose       = 1'b0;
		d          = q;
		d.wr_pulse = 1'b0;
		// device address pins come from outside and are resynchronised
		d.addr_s1  = phy_addr_i;
		d.addr_s2  = q.addr_s1;
		if (link.mdc_rise) begin
			case (q.st)
				mdio_port_pkg::ST_PREAMBLE: begin
					if (!b) begin
						d.cnt = '0;
					end else if (last_bit(q.cnt, mdio_port_pkg::PREAMBLE_LEN)) begin
						d.in_sync = 1'b1;
						d.st      = mdio_port_pkg::ST_IDLE;
						d.cnt     = '0;
					end else begin
						d.cnt = q.cnt + 6'h01;
					end
				end
				mdio_port_pkg::ST_IDLE: begin
					if (!b) begin
						d.st = mdio_port_pkg::ST_START2;
					end
				end
				mdio_port_pkg::ST_START2: begin
					if (b) begin
						d.st  = mdio_port_pkg::ST_OP;
						d.cnt = '0;
					end else begin
						lose = 1'b1;
					end
				end
				mdio_port_pkg::ST_OP: begin
					d.op = {q.op[0], b};
					if (last_bit(q.cnt, mdio_port_pkg::OP_LEN)) begin
						d.cnt = '0;
						if ({q.op[0], b} == mdio_port_pkg::OP_READ ||
						    {q.op[0], b} == mdio_port_pkg::OP_WRITE) begin
							d.st = mdio_port_pkg::ST_PHY;
						end else begin
							lose = 1'b1;
						end
					end else begin
						d.cnt = q.cnt + 6'h01;
					end
				end
				mdio_port_pkg::ST_PHY: begin
					d.phy = {q.phy[3:0], b};
					if (last_bit(q.cnt, mdio_port_pkg::ADDR_W)) begin
						d.match = ({q.phy[3:0], b} == q.addr_s2);
						d.st    = mdio_port_pkg::ST_REG;
						d.cnt   = '0;
					end else begin
						d.cnt = q.cnt + 6'h01;
					end
				end
				mdio_port_pkg::ST_REG: begin
					d.reg_addr = {q.reg_addr[3:0], b};
					if (last_bit(q.cnt, mdio_port_pkg::ADDR_W)) begin
						d.st  = mdio_port_pkg::ST_TA1;
						d.cnt = '0;
					end else begin
						d.cnt = q.cnt + 6'h01;
					end
				end
				mdio_port_pkg::ST_TA1: begin
					// first turnaround bit must read high in both directions; a low bit loses sync
					if (!b) begin
						lose = 1'b1;
					end else begin
						d.st = mdio_port_pkg::ST_TA2;
						if (q.op == mdio_port_pkg::OP_READ && q.match) begin
							d.mdio_oe  = 1'b1;
							d.mdio_out = 1'b0;
							d.shift    = read_word(q.regs, q.reg_addr, status_i);
						end
					end
				end
				mdio_port_pkg::ST_TA2: begin
					d.cnt = '0;
					d.st  = mdio_port_pkg::ST_DATA;
					if (q.op == mdio_port_pkg::OP_READ) begin
						if (q.match) begin
							d.mdio_out = q.shift[15];
							d.shift    = {q.shift[14:0], 1'b0};
						end
					end else if (b) begin
						lose = 1'b1;
					end
				end
				mdio_port_pkg::ST_DATA: begin
					// unmatched reads leave the data output low; the line is not ours
					if (q.op == mdio_port_pkg::OP_READ) begin
						if (q.match) begin
							d.mdio_out = q.shift[15];
							d.shift    = {q.shift[14:0], 1'b0};
						end
					end else begin
						d.shift = {q.shift[14:0], b};
					end
					if (last_bit(q.cnt, mdio_port_pkg::DATA_LEN)) begin
						d.st       = mdio_port_pkg::ST_IDLE;
						d.cnt      = '0;
						d.mdio_oe  = 1'b0;
						d.mdio_out = 1'b0;
						if (q.op == mdio_port_pkg::OP_WRITE && q.match) begin
							d.wr_pulse = 1'b1;
							d.wr_addr  = q.reg_addr;
							d.wr_data  = {q.shift[14:0], b};
							// status register is read only; control reset bit self-clears
							if (q.reg_addr != mdio_port_pkg::ADDR_BASIC_STATUS) begin
								d.regs[q.reg_addr] = {q.shift[14:0], b};
							end
							if (q.reg_addr == mdio_port_pkg::ADDR_CONTROL &&
							    q.shift[mdio_port_pkg::SOFT_RESET_BIT - 1]) begin
								d.regs = {mdio_port_pkg::REG_COUNT{mdio_port_pkg::REG_RESET}};
								lose   = 1'b1;
							end
						end
					end else begin
						d.cnt = q.cnt + 6'h01;
					end
				end
				default: begin
					lose = 1'b1;
				end
			endcase
		end
		if (lose) begin
			d.st       = mdio_port_pkg::ST_PREAMBLE;
			d.cnt      = '0;
			d.in_sync  = 1'b0;
			d.mdio_oe  = 1'b0;
			d.mdio_out = 1'b0;
		end
	end

	// a stopped management clock simply freezes the engine mid-frame
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			q      <= '0;
			q.st   <= mdio_port_pkg::ST_PREAMBLE;
			q.regs <= {mdio_port_pkg::REG_COUNT{mdio_port_pkg::REG_RESET}};
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// outputs
	assign mdio_o     = q.mdio_out;
	assign mdio_oe_o  = q.mdio_oe;
	assign in_sync_o  = q.in_sync;
	assign wr_pulse_o = q.wr_pulse;
	assign wr_addr_o  = q.wr_addr;
	assign wr_data_o  = q.wr_data;

endmodule : mdio_management_port

// >>> test/mdio_chk.sv
// assertions on the management port pins
`timescale 1ns/1ps
module mdio_chk (
	input logic        clk_i,
	input logic        reset_i,
	input logic        mdc_i,
	input logic        mdio_i,
	input logic        mdio_o,
	input logic        mdio_oe_o,
	input logic [4:0]  phy_addr_i,
	input logic [15:0] status_i,
	input logic        in_sync_o,
	input logic        wr_pulse_o,
	input logic [4:0]  wr_addr_o,
	input logic [15:0] wr_data_o
);
	// ==========================
	// raw clock rises, kept a few cycles since the pin is async
	logic [1:0] mdc_q;
	logic [5:0] hist_q;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			mdc_q <= 2'h0;
			hist_q <= 6'h00;
		end else begin
			mdc_q <= {mdc_q[0], mdc_i};
			hist_q <= {hist_q[4:0], mdc_q[0] & ~mdc_q[1]};
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	property p_quiet; !in_sync_o |-> !mdio_oe_o; endproperty
	a_quiet: assert property (p_quiet) else $error("drive unsynced");
	property p_edge; $changed({mdio_oe_o, mdio_o}) |-> |hist_q; endproperty
	a_edge: assert property (p_edge) else $error("drive off edge");
	property p_tazero; $rose(mdio_oe_o) |-> !mdio_o; endproperty
	a_tazero: assert property (p_tazero) else $error("ta2 not zero");
	property p_syncedge; $rose(in_sync_o) |-> |hist_q; endproperty
	a_syncedge: assert property (p_syncedge) else $error("sync off edge");
	property p_pulse; wr_pulse_o |=> !wr_pulse_o; endproperty
	a_pulse: assert property (p_pulse) else $error("long pulse");
	property p_wrsync; wr_pulse_o |-> $past(in_sync_o); endproperty
	a_wrsync: assert property (p_wrsync) else $error("write unsynced");
	property p_hold; !wr_pulse_o |-> $stable({wr_addr_o, wr_data_o}); endproperty
	a_hold: assert property (p_hold) else $error("write moved");
	property p_idle; !mdio_oe_o |-> !mdio_o; endproperty
	a_idle: assert property (p_idle) else $error("idle not low");
	c_drive: cover property ($rose(mdio_oe_o));
	c_write: cover property (wr_pulse_o);
	c_lost: cover property ($fell(in_sync_o));
endmodule : mdio_chk
bind mdio_management_port mdio_chk u_chk (.*);

// >>> test/mgmt_station.sv
// station model driving the management clock and data line
`timescale 1ns/1ps
module mgmt_station (
	output logic mdc_o,
	output logic mdio_o,
	output logic mdio_oe_o,
	input  logic mdio_i
);
	// ==========================
	// 12.5 MHz clock, low outside frames
	logic smp;
	initial begin
		mdc_o = 1'b0;
		mdio_o = 1'b0;
		mdio_oe_o = 1'b0;
	end
	task automatic bit_x(input logic b, input logic oe);
		mdio_o = b;
		mdio_oe_o = oe;
		#40 mdc_o = 1'b1;
		smp = mdio_i;
		#40 mdc_o = 1'b0;
	endtask : bit_x
	// released: pull-up holds ones
	task automatic ones(input int n);
		repeat (n) bit_x(1'b1, 1'b0);
	endtask : ones
	task automatic frame(input logic [3:0] hd, input logic [4:0] pa, input logic [4:0] ra,
		input logic [1:0] ta, input logic [15:0] wd, output logic [16:0] rd);
		logic [13:0] h;
		h = {hd, pa, ra};
		rd = 17'h0_0000;
		bit_x(1'b1, 1'b1);
		for (int i = 13; i >= 0; i--) bit_x(h[i], 1'b1);
		if (hd[1:0] == mdio_port_pkg::OP_READ) begin
			bit_x(1'b1, 1'b0);
			for (int i = 16; i >= 0; i--) begin
				bit_x(1'b1, 1'b0);
				rd[i] = smp;
			end
		end else begin
			bit_x(ta[1], 1'b1);
			bit_x(ta[0], 1'b1);
			for (int i = 15; i >= 0; i--) bit_x(wd[i], 1'b1);
		end
		bit_x(1'b1, 1'b0);
	endtask : frame
endmodule : mgmt_station

// >>> test/tb_top.sv
// testbench for the serial management port
`timescale 1ns/1ps
module tb_top;
	// ==========================
	// clock, reset, shared line with pull-up
	localparam logic [4:0] me = 5'h03;
	localparam logic [3:0] rdop = {2'h1, mdio_port_pkg::OP_READ};
	localparam logic [3:0] wrop = {2'h1, mdio_port_pkg::OP_WRITE};
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        mdc, s_out, s_oe, d_out, d_oe, sync, pulse;
	logic [4:0]  wa;
	logic [15:0] wd;
	logic [16:0] rd;
	int          n_mismatch = 0;
	int          n_tests = 0;
	int          n_pulse = 0;
	int          p0;
	wire         mdio_w = d_oe ? d_out : (s_oe ? s_out : 1'b1);
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) n_pulse <= n_pulse + int'(pulse);
	mdio_management_port dut (.clk_i(clk_i), .reset_i(reset_i), .mdc_i(mdc), .mdio_i(mdio_w),
		.mdio_o(d_out), .mdio_oe_o(d_oe), .phy_addr_i(me), .status_i(16'h1234),
		.in_sync_o(sync), .wr_pulse_o(pulse), .wr_addr_o(wa), .wr_data_o(wd));
	mgmt_station stn (.mdc_o(mdc), .mdio_o(s_out), .mdio_oe_o(s_oe), .mdio_i(mdio_w));
	// ==========================
	// shared tasks
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
		p0 = n_pulse;
		stn.frame(wrop, pa, ra, 2'h2, d, rd);
		repeat (8) @(posedge clk_i);
		#1;
	endtask : wr
	task automatic rdc(input logic [4:0] pa, input logic [4:0] ra, input logic [16:0] e);
		stn.frame(rdop, pa, ra, 2'h2, 16'h0000, rd);
		chk(rd, e);
	endtask : rdc
	task automatic final_report;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report
	// ==========================
	// scenarios
	task automatic t_basic;
		rdc(me, 5'h01, 17'h1_FFFF);
		chk({16'h0000, sync}, 17'h0_0000);
		stn.ones(32);
		repeat (8) @(posedge clk_i);
		#1;
		chk({16'h0000, sync}, 17'h0_0001);
		wr(me, 5'h05, 16'hA5C3);
		chk(17'(n_pulse - p0), 17'h0_0001);
		chk({12'h000, wa}, 17'h0_0005);
		chk({1'h0, wd}, 17'h0_A5C3);
		wr(me, 5'h1F, 16'h5A3C);
		rdc(me, 5'h05, 17'h0_A5C3);
		rdc(me, 5'h1F, 17'h0_5A3C);
		wr(me, 5'h01, 16'h0000);
		rdc(me, 5'h01, 17'h0_1274);
		wr(5'h1F, 5'h05, 16'h0F0F);
		chk(17'(n_pulse - p0), 17'h0_0000);
		rdc(5'h1F, 5'h05, 17'h1_FFFF);
		rdc(me, 5'h05, 17'h0_A5C3);
	endtask : t_basic
	task automatic t_bad;
		logic [5:0] tbl [4] = '{6'h0A, 6'h12, 6'h1E, 6'h17};
		for (int i = 0; i < 4; i++) begin
			stn.frame(tbl[i][5:2], me, 5'h05, tbl[i][1:0], 16'hFFFF, rd);
			repeat (8) @(posedge clk_i);
			#1;
			chk({16'h0000, sync}, 17'h0_0000);
			rdc(me, 5'h05, 17'h1_FFFF);
			stn.ones(32);
			rdc(me, 5'h05, 17'h0_A5C3);
		end
	endtask : t_bad
	task automatic t_reset;
		// hardware reset mid-run, then software reset through control bit 15
		@(posedge clk_i);
		#1;
		reset_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		reset_i = 1'b0;
		chk({16'h0000, sync}, 17'h0_0000);
		rdc(me, 5'h1F, 17'h1_FFFF);
		stn.ones(32);
		rdc(me, 5'h1F, 17'h0_0000);
		wr(me, 5'h05, 16'hA5C3);
		wr(me, 5'h00, 16'h8000);
		chk({16'h0000, sync}, 17'h0_0000);
		stn.ones(32);
		rdc(me, 5'h05, 17'h0_0000);
	endtask : t_reset
	initial begin
		repeat (8) @(posedge clk_i);
		#1 reset_i = 1'b0;
		t_basic();
		t_bad();
		t_reset();
		final_report();
	end
	initial begin
		#500000;
		n_mismatch++;
		final_report();
	end
endmodule : tb_top
